// ### csw_pin_ctr.v
// pin retry counter with blocking at zero
`timescale 1ns/100ps
`include "csw_regs.vh"

module csw_pin_ctr (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire       i_fail,
	input  wire       i_restore,
	output reg  [3:0] o_tries,
	output wire       o_blocked
);

	assign o_blocked = (o_tries == 4'h0);

	always @(posedge i_clk) begin
		if (i_rst) begin
			o_tries <= `CSW_PIN_MAX;
		end else if (i_restore) begin
			o_tries <= `CSW_PIN_MAX;
		// (R9) decrement on failure
		end else if (i_fail && !o_blocked) begin
			o_tries <= o_tries - 4'h1;
		end
	end

endmodule // csw_pin_ctr

// ### csw_regs.vh
// constants of the card status word responder
`ifndef CSW_REGS_VH
`define CSW_REGS_VH

// instruction codes
`define CSW_INS_SELECT    8'ha4
`define CSW_INS_STATUS    8'hf2
`define CSW_INS_RD_BIN    8'hb0
`define CSW_INS_UPD_BIN   8'hd6
`define CSW_INS_RD_REC    8'hb2
`define CSW_INS_VERIFY    8'h20
`define CSW_INS_UNBLOCK   8'h2c
`define CSW_INS_GET_RESP  8'hc0
`define CSW_INS_ENVELOPE  8'hc2

// class byte fields
`define CSW_CLA_TYPE      7:4
`define CSW_CLA_SM        3:2
`define CSW_CLA_CHAN      1:0
`define CSW_CLA_INTER     4'h0
`define CSW_CLA_PROP      4'h8

// parameter fields
`define CSW_P1_SFI_BIT    7
`define CSW_P1_OFS_HI     6:0
`define CSW_REC_MODE      2:0
`define CSW_MODE_NEXT     3'h2
`define CSW_MODE_PREV     3'h3
`define CSW_MODE_ABS      3'h4
`define CSW_SEL_BY_FID    8'h00
`define CSW_SEL_BY_AID    8'h04
`define CSW_FID_LEN       8'h02
`define CSW_AID_MIN       8'h05
`define CSW_AID_MAX       8'h10

// pin retry counter
`define CSW_PIN_MAX       4'h3

// first and second status byte values
`define CSW_SW1_OK        8'h90
`define CSW_SW1_PROACT    8'h91
`define CSW_SW1_TK_BUSY   8'h93
`define CSW_SW1_WARN      8'h62
`define CSW_SW1_RETRY     8'h63
`define CSW_SW2_RETRY_HI  4'hc
`define CSW_SW2_NONE      8'h00

// full status words
`define CSW_SW_OK         16'h9000
`define CSW_SW_TK_BUSY    16'h9300
`define CSW_SW_WARN_NONE  16'h6200
`define CSW_SW_WARN_CORR  16'h6281
`define CSW_SW_WARN_EOF   16'h6282
`define CSW_SW_WARN_INVAL 16'h6283
`define CSW_SW_EXEC_KEEP  16'h6400
`define CSW_SW_EXEC_CHG   16'h6500
`define CSW_SW_EXEC_MEM   16'h6581
`define CSW_SW_WRONG_LEN  16'h6700
`define CSW_SW_NO_CHAN    16'h6881
`define CSW_SW_NO_SM      16'h6882
`define CSW_SW_STRUCT     16'h6981
`define CSW_SW_SECURITY   16'h6982
`define CSW_SW_BLOCKED    16'h6983
`define CSW_SW_NO_EF      16'h6986
`define CSW_SW_NOT_FOUND  16'h6a82
`define CSW_SW_NO_RECORD  16'h6a83
`define CSW_SW_BAD_P1P2   16'h6b00
`define CSW_SW_BAD_INS    16'h6d00
`define CSW_SW_BAD_CLA    16'h6e00
`define CSW_SW_TECH       16'h6f00

// completion condition codes from the data path
`define CSW_EX_OK         3'h0
`define CSW_EX_WARN_NONE  3'h1
`define CSW_EX_WARN_CORR  3'h2
`define CSW_EX_WARN_EOF   3'h3
`define CSW_EX_WARN_INVAL 3'h4
`define CSW_EX_KEEP       3'h5
`define CSW_EX_CHANGED    3'h6
`define CSW_EX_MEMORY     3'h7

`endif

// ### csw_resp_sva.sv
// checker of the status word responder ports
`timescale 1ns/100ps
module csw_resp_sva (
	input wire       i_clk,
	input wire       i_rst,
	input wire       i_cmd_valid,
	input wire [7:0] i_cla,
	input wire [7:0] i_ins,
	input wire       i_pin_match,
	input wire       i_resp_pending,
	input wire       i_proact_pending,
	input wire       i_toolkit_busy,
	input wire [2:0] i_exec_cond,
	input wire       i_sw_ready,
	input wire       o_cmd_ready,
	input wire       o_sw_valid,
	input wire [7:0] o_sw_byte,
	input wire       o_sw_last,
	input wire [7:0] o_sw1,
	input wire [7:0] o_sw2,
	input wire [3:0] o_pin_tries,
	input wire       o_pin_blocked
);
	wire        tk = i_cmd_valid && o_cmd_ready;
	wire        t  = tk && i_cla == 8'h00;
	wire        ct = i_cla[7:4] == 4'h0 || i_cla[7:4] == 4'h8;
	wire [15:0] sw = {o_sw1, o_sw2};
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	//////////////////////////////
	take_answer_a: assert property (tk |=> o_sw_valid && !o_sw_last && !o_cmd_ready)
		else $error("no first byte after take");
	byte_order_a: assert property (o_sw_valid && !o_sw_last && i_sw_ready |=> o_sw_last && o_sw_byte == o_sw2)
		else $error("second byte wrong");
	first_byte_a: assert property ($rose(o_sw_valid) |-> o_sw_byte == o_sw1)
		else $error("first byte wrong");
	status_ok_a: assert property (t && i_ins == 8'hf2 && i_exec_cond == 3'h0 && !i_proact_pending |=> sw == 16'h9000)
		else $error("normal end wrong");
	bad_ins_a: assert property (t && i_ins == 8'h6f |=> sw == 16'h6d00)
		else $error("unknown ins wrong");
	bad_class_a: assert property (tk && !ct |=> sw == 16'h6e00)
		else $error("class reject wrong");
	chan_reject_a: assert property (tk && ct && i_cla[1:0] != 2'h0 |=> sw == 16'h6881)
		else $error("channel reject wrong");
	pin_blocked_a: assert property (t && i_ins == 8'h20 && o_pin_blocked |=> sw == 16'h6983)
		else $error("blocked pin wrong");
	pin_retry_a: assert property (t && i_ins == 8'h20 && !o_pin_blocked && !i_pin_match
		|=> o_sw1 == 8'h63 && o_sw2 == {4'hc, o_pin_tries} && o_pin_tries == $past(o_pin_tries) - 4'h1)
		else $error("pin retry wrong");
	no_resp_a: assert property (t && i_ins == 8'hc0 && !i_resp_pending |=> sw == 16'h6f00)
		else $error("empty fetch wrong");
	tk_busy_a: assert property (t && i_ins == 8'hc2 && i_toolkit_busy |=> sw == 16'h9300)
		else $error("toolkit busy wrong");
endmodule // csw_resp_sva

bind csw_responder csw_resp_sva i_sva (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cla(i_cla),
	.i_ins(i_ins), .i_pin_match(i_pin_match), .i_resp_pending(i_resp_pending), .i_proact_pending(i_proact_pending),
	.i_toolkit_busy(i_toolkit_busy), .i_exec_cond(i_exec_cond), .i_sw_ready(i_sw_ready), .o_cmd_ready(o_cmd_ready),
	.o_sw_valid(o_sw_valid), .o_sw_byte(o_sw_byte), .o_sw_last(o_sw_last), .o_sw1(o_sw1), .o_sw2(o_sw2),
	.o_pin_tries(o_pin_tries), .o_pin_blocked(o_pin_blocked));

// ### csw_responder.v
// status word generation of the card command interpreter
`timescale 1ns/100ps
`include "csw_regs.vh"

// What this block does
// (R1) terminal frames: class, ins, p1, p2, data
// (R2) answer ends with two status bytes
// (R3) normal completion answers 90 00
// (R4) no elementary file selected: 69 86
// (R5) invalid read offset: 6B 00
// (R6) record beyond range: 6A 83
// (R7) binary read on record file: 69 81
// (R8) selection length mismatch: 67 00
// (R9) failed pin decrements, reports 63 CX
// (R10) blocked pin verification: 69 83
// (R11) undefined record mode: 6B 00
// (R12) unknown instruction: 6D 00
// (R13) no pending response data: 6F 00
// (R14) unsupported class byte: 6E 00
// (R15) nonzero logical channel: 68 81
// (R16) secure messaging requested: 68 82
// (R17) unknown file identifier: 6A 82
// (R18) write access not granted: 69 82
// (R19) pending proactive command: 91 length; successful verify, unblock and get response still answer 90 00
// (R20) toolkit busy: 93 00, others proceed
// (R21) warnings use first byte 62
// (R22) execution errors 64 00, 65 00/81
// (R23) generic 00 for 67 and 6F
// (R24) class, ins, params, file: first wins; binary read and update check the file before the offset

module csw_responder (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_cmd_valid,
	input  wire [7:0]  i_cla,
	input  wire [7:0]  i_ins,
	input  wire [7:0]  i_p1,
	input  wire [7:0]  i_p2,
	input  wire        i_lc_present,
	input  wire [7:0]  i_lc,
	input  wire        i_ef_selected,
	input  wire        i_ef_is_record,
	input  wire [15:0] i_ef_size,
	input  wire [7:0]  i_rec_count,
	input  wire        i_file_found,
	input  wire        i_write_allowed,
	input  wire        i_pin_match,
	input  wire        i_resp_pending,
	input  wire        i_proact_pending,
	input  wire [7:0]  i_proact_len,
	input  wire        i_toolkit_busy,
	input  wire [2:0]  i_exec_cond,
	input  wire        i_sw_ready,
	output wire        o_cmd_ready,
	output wire        o_sw_valid,
	output reg  [7:0]  o_sw_byte,
	output wire        o_sw_last,
	output reg  [7:0]  o_sw1,
	output reg  [7:0]  o_sw2,
	output reg  [7:0]  o_rec_ptr,
	output wire [3:0]  o_pin_tries,
	output wire        o_pin_blocked
);

	// answer sequencer states
	localparam [1:0] ST_IDLE   = 2'b00;
	localparam [1:0] ST_FIRST  = 2'b01;
	localparam [1:0] ST_SECOND = 2'b10;

	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [15:0] next_sw;
	reg  [7:0]  next_ptr;
	reg         pin_fail;
	reg         pin_restore;
	wire        take;
	wire [15:0] offset;

	////////////////////////////////////////////////////////////////////////
	// completion code mapping

	// (R21) (R22) data path condition to word
	function [15:0] csw_complete;
		input [2:0] cond;
		begin
			case (cond)
				`CSW_EX_WARN_NONE:  csw_complete = `CSW_SW_WARN_NONE;
				`CSW_EX_WARN_CORR:  csw_complete = `CSW_SW_WARN_CORR;
				`CSW_EX_WARN_EOF:   csw_complete = `CSW_SW_WARN_EOF;
				`CSW_EX_WARN_INVAL: csw_complete = `CSW_SW_WARN_INVAL;
				`CSW_EX_KEEP:       csw_complete = `CSW_SW_EXEC_KEEP;
				`CSW_EX_CHANGED:    csw_complete = `CSW_SW_EXEC_CHG;
				`CSW_EX_MEMORY:     csw_complete = `CSW_SW_EXEC_MEM;
				// (R3) normal ending
				default:            csw_complete = `CSW_SW_OK;
			endcase
		end
	endfunction

	// (R19) proactive length replaces the plain ok
	function [15:0] csw_ok_word;
		input [2:0] cond;
		input       proact;
		input [7:0] plen;
		begin
			if (cond == `CSW_EX_OK && proact) begin
				csw_ok_word = {`CSW_SW1_PROACT, plen};
			end else begin
				csw_ok_word = csw_complete(cond);
			end
		end
	endfunction

	// (R11) only next, previous and absolute are defined
	function csw_rec_mode_ok;
		input [2:0] mode;
		begin
			case (mode)
				`CSW_MODE_NEXT, `CSW_MODE_PREV, `CSW_MODE_ABS: csw_rec_mode_ok = 1'b1;
				default: csw_rec_mode_ok = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// command acceptance

	// new commands wait until both status bytes are out
	assign o_cmd_ready = (state == ST_IDLE);
	assign take        = i_cmd_valid && o_cmd_ready;
	assign offset      = {1'b0, i_p1[`CSW_P1_OFS_HI], i_p2};

	////////////////////////////////////////////////////////////////////////
	// status decision

	always @* begin
		next_sw     = `CSW_SW_OK;
		next_ptr    = o_rec_ptr;
		pin_fail    = 1'b0;
		pin_restore = 1'b0;
		// (R24) class checks come first
		// (R14) only inter-industry or proprietary class
		if (i_cla[`CSW_CLA_TYPE] != `CSW_CLA_INTER &&
		    i_cla[`CSW_CLA_TYPE] != `CSW_CLA_PROP) begin
			next_sw = `CSW_SW_BAD_CLA;
		// (R15) only the basic channel exists
		end else if (i_cla[`CSW_CLA_CHAN] != 2'h0) begin
			next_sw = `CSW_SW_NO_CHAN;
		// (R16) no secure messaging
		end else if (i_cla[`CSW_CLA_SM] != 2'h0) begin
			next_sw = `CSW_SW_NO_SM;
		end else begin
			case (i_ins)
				`CSW_INS_SELECT: begin
					// (R8) length must fit the selection method
					if (i_p1 == `CSW_SEL_BY_FID && i_lc_present &&
					    i_lc != `CSW_FID_LEN) begin
						next_sw = `CSW_SW_WRONG_LEN;
					end else if (i_p1 == `CSW_SEL_BY_AID &&
					    (i_lc < `CSW_AID_MIN || i_lc > `CSW_AID_MAX)) begin
						next_sw = `CSW_SW_WRONG_LEN;
					end else if (i_p1 != `CSW_SEL_BY_FID &&
					    i_p1 != `CSW_SEL_BY_AID) begin
						next_sw = `CSW_SW_BAD_P1P2;
					// (R17) unknown identifier
					end else if (i_lc_present && !i_file_found) begin
						next_sw = `CSW_SW_NOT_FOUND;
					end else begin
						// record pointer undefined after selection
						next_ptr = 8'h00;
						next_sw  = csw_ok_word(i_exec_cond,
						    i_proact_pending, i_proact_len);
					end
				end
				`CSW_INS_RD_BIN, `CSW_INS_UPD_BIN: begin
					// (R4) plain read needs a selected file
					if (!i_p1[`CSW_P1_SFI_BIT] && !i_ef_selected) begin
						next_sw = `CSW_SW_NO_EF;
					// (R7) binary access on record file
					end else if (i_ef_is_record) begin
						next_sw = `CSW_SW_STRUCT;
					// (R5) offset past the end of file
					end else if (!i_p1[`CSW_P1_SFI_BIT] &&
					    offset >= i_ef_size) begin
						next_sw = `CSW_SW_BAD_P1P2;
					// (R18) write access condition
					end else if (i_ins == `CSW_INS_UPD_BIN &&
					    !i_write_allowed) begin
						next_sw = `CSW_SW_SECURITY;
					end else begin
						next_sw = csw_ok_word(i_exec_cond,
						    i_proact_pending, i_proact_len);
					end
				end
				`CSW_INS_RD_REC: begin
					// (R24) a bad mode is a parameter fault, ahead of file state
					if (!csw_rec_mode_ok(i_p2[`CSW_REC_MODE])) begin
						next_sw = `CSW_SW_BAD_P1P2;
					// record read needs a selected file
					end else if (!i_ef_selected) begin
						next_sw = `CSW_SW_NO_EF;
					end else begin
						case (i_p2[`CSW_REC_MODE])
							// (R6) next beyond last record
							`CSW_MODE_NEXT: begin
								if (o_rec_ptr >= i_rec_count) begin
									next_sw = `CSW_SW_NO_RECORD;
								end else begin
									next_ptr = o_rec_ptr + 8'h01;
								end
							end
							// (R6) previous before first record
							`CSW_MODE_PREV: begin
								if (o_rec_ptr == 8'h01 || i_rec_count == 8'h00) begin
									next_sw = `CSW_SW_NO_RECORD;
								end else if (o_rec_ptr == 8'h00) begin
									next_ptr = i_rec_count;
								end else begin
									next_ptr = o_rec_ptr - 8'h01;
								end
							end
							`CSW_MODE_ABS: begin
								if ((i_p1 == 8'h00 && o_rec_ptr == 8'h00) ||
								    i_p1 > i_rec_count) begin
									next_sw = `CSW_SW_NO_RECORD;
								end
							end
							// (R11) undefined record mode
							default: next_sw = `CSW_SW_BAD_P1P2;
						endcase
						if (next_sw == `CSW_SW_OK) begin
							next_sw = csw_ok_word(i_exec_cond,
							    i_proact_pending, i_proact_len);
						end
					end
				end
				`CSW_INS_VERIFY: begin
					// (R10) blocked method refuses
					if (o_pin_blocked) begin
						next_sw = `CSW_SW_BLOCKED;
					// (R3) correct pin restores the counter
					end else if (i_pin_match) begin
						pin_restore = 1'b1;
						next_sw     = `CSW_SW_OK;
					// (R9) report tries left after this failure
					end else begin
						pin_fail = 1'b1;
						next_sw  = {`CSW_SW1_RETRY, `CSW_SW2_RETRY_HI,
						    o_pin_tries - 4'h1};
					end
				end
				`CSW_INS_UNBLOCK: begin
					if (i_pin_match) begin
						pin_restore = 1'b1;
					end else begin
						next_sw = `CSW_SW_SECURITY;
					end
				end
				`CSW_INS_GET_RESP: begin
					// (R13) (R23) generic second byte only
					if (!i_resp_pending) begin
						next_sw = `CSW_SW_TECH;
					end
				end
				`CSW_INS_ENVELOPE: begin
					// (R20) busy toolkit; other commands unaffected
					if (i_toolkit_busy) begin
						next_sw = `CSW_SW_TK_BUSY;
					end else begin
						next_sw = csw_ok_word(i_exec_cond,
						    i_proact_pending, i_proact_len);
					end
				end
				`CSW_INS_STATUS: begin
					next_sw = csw_ok_word(i_exec_cond,
					    i_proact_pending, i_proact_len);
				end
				// (R12) unsupported instruction
				default: next_sw = `CSW_SW_BAD_INS;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin counter

	csw_pin_ctr u_pin (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_fail    (take && pin_fail),
		.i_restore (take && pin_restore),
		.o_tries   (o_pin_tries),
		.o_blocked (o_pin_blocked)
	);

	////////////////////////////////////////////////////////////////////////
	// answer sequencer

	assign o_sw_valid = (state != ST_IDLE);
	assign o_sw_last  = (state == ST_SECOND);

	// a byte moves on only when the consumer takes it
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (take) begin
					next_state = ST_FIRST;
				end
			end
			ST_FIRST: begin
				if (i_sw_ready) begin
					next_state = ST_SECOND;
				end
			end
			ST_SECOND: begin
				if (i_sw_ready) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// (R2) first byte, then second byte
	always @(posedge i_clk) begin
		if (i_rst) begin
			state     <= ST_IDLE;
			o_sw_byte <= 8'h00;
			o_sw1     <= 8'h00;
			o_sw2     <= 8'h00;
			o_rec_ptr <= 8'h00;
		end else begin
			state <= next_state;
			// sw1/sw2 stand until the next take
			if (take) begin
				o_sw1     <= next_sw[15:8];
				o_sw2     <= next_sw[7:0];
				o_sw_byte <= next_sw[15:8];
				o_rec_ptr <= next_ptr;
			end else if (state == ST_FIRST && i_sw_ready) begin
				o_sw_byte <= o_sw2;
			end
		end
	end

endmodule // csw_responder

// ### csw_tb.sv
// self-checking bench of the status word responder
`timescale 1ns/100ps
module testbench;
	localparam [7:0] nil = 8'h00;
	logic        i_clk = 1'b0, i_rst = 1'b1;
	logic        sel = 0, rec = 0, fnd = 0, wr = 0, pin = 0, rsp = 0, pro = 0, busy = 0;
	logic [15:0] size = 16'h0000;
	logic [7:0]  recs = 8'h00, plen = 8'h00, c;
	logic [2:0]  cond = 3'h0;
	wire         vld, lcp, rdy, cmd_rdy, sw_vld, sw_last, blk;
	wire  [7:0]  cla, ins, p1, p2, lc, sw_byte, sw1, sw2, ptr;
	wire  [3:0]  tries;
	wire  [15:0] word;
	int          num_errors = 0, checks_done = 0;
	logic [15:0] exm [8] = '{16'h9000, 16'h6200, 16'h6281, 16'h6282, 16'h6283, 16'h6400, 16'h6500, 16'h6581};
	csw_responder i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(vld), .i_cla(cla), .i_ins(ins), .i_p1(p1),
		.i_p2(p2), .i_lc_present(lcp), .i_lc(lc), .i_ef_selected(sel), .i_ef_is_record(rec), .i_ef_size(size),
		.i_rec_count(recs), .i_file_found(fnd), .i_write_allowed(wr), .i_pin_match(pin), .i_resp_pending(rsp),
		.i_proact_pending(pro), .i_proact_len(plen), .i_toolkit_busy(busy), .i_exec_cond(cond), .i_sw_ready(rdy),
		.o_cmd_ready(cmd_rdy), .o_sw_valid(sw_vld), .o_sw_byte(sw_byte), .o_sw_last(sw_last), .o_sw1(sw1),
		.o_sw2(sw2), .o_rec_ptr(ptr), .o_pin_tries(tries), .o_pin_blocked(blk));
	csw_term i_term (.i_clk(i_clk), .i_sw_valid(sw_vld), .i_sw_byte(sw_byte), .i_sw_last(sw_last),
		.o_cmd_valid(vld), .o_cla(cla), .o_ins(ins), .o_p1(p1), .o_p2(p2), .o_lc_present(lcp), .o_lc(lc),
		.o_sw_ready(rdy), .o_word(word));
	initial forever #12.5 i_clk = ~i_clk;
	//////////////////////////////
	function [15:0] expect_sw(input [7:0] cb, input [2:0] k);
		if (cb[7:4] != 4'h0 && cb[7:4] != 4'h8) return 16'h6e00;
		if (cb[1:0] != 2'h0) return 16'h6881;
		if (cb[3:2] != 2'h0) return 16'h6882;
		return exm[k];
	endfunction
	task chk_sw(input [15:0] e);
		checks_done++;
		if (word !== e || {sw1, sw2} !== e) begin
			num_errors++;
			$display("[FAIL] status word expected %h seen %h", e, word);
		end
	endtask
	task chk_tries(input [3:0] e);
		checks_done++;
		if (tries !== e) begin
			num_errors++;
			$display("[FAIL] pin tries expected %h seen %h", e, tries);
		end
	endtask
	task chk_ptr(input [7:0] e);
		checks_done++;
		if (ptr !== e) begin
			num_errors++;
			$display("[FAIL] record pointer expected %h seen %h", e, ptr);
		end
	endtask
	task cmd(input [7:0] cb, n, a, b, l, input [15:0] e);
		i_term.run({cb, n, a, b, l != nil, l});
		chk_sw(e);
	endtask
	task complete_run;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	//////////////////////////////
	initial begin
		#125000;
		num_errors++;
		complete_run;
	end
	initial begin
		void'($urandom(43));
		repeat (4) @(posedge i_clk);
		@(negedge i_clk) i_rst = 1'b0;
		chk_tries(4'h3);
		for (int k = 0; k < 8; k++) begin
			cond = k[2:0];
			cmd(8'h80, 8'hf2, nil, nil, nil, exm[k]);
		end
		for (int k = 0; k < 24; k++) begin
			c = 8'($urandom);
			cond = 3'($urandom);
			cmd(c, 8'hf2, nil, nil, nil, expect_sw(c, cond));
		end
		cond = 3'h0;
		pro = 1;
		plen = 8'h1c;
		cmd(nil, 8'hf2, nil, nil, nil, 16'h911c);
		pro = 0;
		cmd(8'h40, 8'hc0, nil, nil, nil, 16'h6e00);
		cmd(8'h81, 8'h6f, nil, nil, nil, 16'h6881);
		cmd(8'h84, 8'hf2, nil, nil, nil, 16'h6882);
		cmd(nil, 8'h6f, nil, nil, nil, 16'h6d00);
		cmd(nil, 8'hc0, nil, nil, nil, 16'h6f00);
		rsp = 1;
		cmd(nil, 8'hc0, nil, nil, nil, 16'h9000);
		busy = 1;
		cmd(nil, 8'hc2, nil, nil, nil, 16'h9300);
		cmd(nil, 8'hf2, nil, nil, nil, 16'h9000);
		cmd(nil, 8'hb0, nil, nil, nil, 16'h6986);
		cmd(nil, 8'hb0, 8'h80, nil, nil, 16'h9000);
		cmd(nil, 8'hb2, nil, 8'h01, nil, 16'h6b00);
		sel = 1;
		size = 16'h0008;
		cmd(nil, 8'hb0, nil, 8'h0f, nil, 16'h6b00);
		cmd(nil, 8'hb0, nil, 8'h07, nil, 16'h9000);
		cmd(nil, 8'hd6, nil, nil, 8'h02, 16'h6982);
		rec = 1;
		cmd(nil, 8'hb0, nil, nil, nil, 16'h6981);
		cmd(nil, 8'ha4, nil, nil, 8'h01, 16'h6700);
		cmd(nil, 8'ha4, nil, 8'h04, 8'h02, 16'h6a82);
		cmd(nil, 8'ha4, 8'h01, 8'h04, 8'h02, 16'h6b00);
		cmd(nil, 8'ha4, 8'h04, 8'h04, 8'h03, 16'h6700);
		fnd = 1;
		recs = 8'h02;
		cmd(nil, 8'ha4, nil, 8'h04, 8'h02, 16'h9000);
		cmd(nil, 8'hb2, nil, 8'h02, nil, 16'h9000);
		chk_ptr(8'h01);
		cmd(nil, 8'hb2, nil, 8'h03, nil, 16'h6a83);
		chk_ptr(8'h01);
		cmd(nil, 8'hb2, nil, 8'h02, nil, 16'h9000);
		cmd(nil, 8'hb2, nil, 8'h02, nil, 16'h6a83);
		chk_ptr(8'h02);
		cmd(nil, 8'hb2, 8'h01, 8'h04, nil, 16'h9000);
		cmd(nil, 8'hb2, 8'h03, 8'h04, nil, 16'h6a83);
		chk_ptr(8'h02);
		cmd(nil, 8'ha4, nil, 8'h04, 8'h02, 16'h9000);
		chk_ptr(8'h00);
		cmd(nil, 8'hb2, nil, 8'h01, nil, 16'h6b00);
		for (int k = 0; k < 3; k++) begin
			cmd(nil, 8'h20, nil, 8'h01, 8'h08, {12'h63c, 4'(2 - k)});
			chk_tries(4'(2 - k));
		end
		cmd(nil, 8'h20, nil, 8'h01, 8'h08, 16'h6983);
		cmd(nil, 8'h2c, nil, 8'h01, 8'h10, 16'h6982);
		chk_tries(4'h0);
		pin = 1;
		cmd(nil, 8'h2c, nil, 8'h01, 8'h10, 16'h9000);
		cmd(nil, 8'h20, nil, 8'h01, 8'h08, 16'h9000);
		chk_tries(4'h3);
		busy = 0;
		cmd(nil, 8'hc2, nil, nil, nil, 16'h9000);
		complete_run;
	end
endmodule // testbench

// ### csw_term.sv
// terminal model: sends headers, takes status bytes
`timescale 1ns/100ps
module csw_term (
	input  wire         i_clk,
	input  wire         i_sw_valid,
	input  wire  [7:0]  i_sw_byte,
	input  wire         i_sw_last,
	output logic        o_cmd_valid,
	output logic [7:0]  o_cla,
	output logic [7:0]  o_ins,
	output logic [7:0]  o_p1,
	output logic [7:0]  o_p2,
	output logic        o_lc_present,
	output logic [7:0]  o_lc,
	output logic        o_sw_ready,
	output logic [15:0] o_word
);
	initial begin
		o_cmd_valid = 1'b0;
		o_sw_ready = 1'b0;
		{o_cla, o_ins, o_p1, o_p2, o_lc_present, o_lc} = 41'h0;
		o_word = 16'h0000;
	end
	//////////////////////////////
	task automatic run(input [40:0] hdr);
		int n;
		logic done;
		begin
			done = 1'b0;
			@(negedge i_clk);
			o_cmd_valid = 1'b1;
			{o_cla, o_ins, o_p1, o_p2, o_lc_present, o_lc} = hdr;
			@(negedge i_clk);
			o_cmd_valid = 1'b0;
			// released lines must not echo the old header
			{o_cla, o_ins, o_p1, o_p2, o_lc_present, o_lc} = ~hdr;
			o_word = 16'hxxxx;
			for (n = 0; n < 40 && !done; n++) begin
				if (n > 0) @(negedge i_clk);
				o_sw_ready = 1'($urandom % 2);
				if (o_sw_ready && i_sw_valid) begin
					o_word = {o_word[7:0], i_sw_byte};
					done = i_sw_last;
				end
			end
		end
	endtask
endmodule // csw_term
